// ---- shared/vcii_pkg.sv ----
package vcii_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [13:0] OFS_CONTROL    = 14'h0000;
  localparam logic [13:0] OFS_PRIO_MASK  = 14'h0004;
  localparam logic [13:0] OFS_BIN_POINT  = 14'h0008;
  localparam logic [13:0] OFS_ACK        = 14'h000C;
  localparam logic [13:0] OFS_EOI        = 14'h0010;
  localparam logic [13:0] OFS_RUN_PRIO   = 14'h0014;
  localparam logic [13:0] OFS_HIGH_PEND  = 14'h0018;
  localparam logic [13:0] OFS_ABIN_POINT = 14'h001C;
  localparam logic [13:0] OFS_AACK       = 14'h0020;
  localparam logic [13:0] OFS_AEOI       = 14'h0024;
  localparam logic [13:0] OFS_AHIGH_PEND = 14'h0028;
  localparam logic [13:0] OFS_ACT_PRIO   = 14'h00D0;
  localparam logic [13:0] OFS_IDENT      = 14'h00FC;
  localparam logic [13:0] OFS_DEACTIVATE = 14'h1000;
  // Hypervisor view and event registers
  localparam logic [13:0] OFS_TYPE       = 14'h2004;
  localparam logic [13:0] OFS_HYP_APR    = 14'h20F0;
  localparam logic [13:0] OFS_LIST_BASE  = 14'h2100;
  localparam logic [13:0] OFS_EVT_STATUS = 14'h2200;
  localparam logic [13:0] OFS_EVT_MASK   = 14'h2204;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [9:0]  RST_CONTROL    = 10'h000;
  localparam logic [7:0]  RST_PRIO_MASK  = 8'h00;
  localparam logic [2:0]  RST_BIN_POINT  = 3'h2;
  localparam logic [2:0]  RST_ABIN_POINT = 3'h3;
  localparam logic [31:0] RST_ACT_PRIO   = 32'h00000000;
  localparam logic [7:0]  IDLE_PRIORITY  = 8'hFF;
  localparam logic [9:0]  SPURIOUS_ID    = 10'h3FF;
  localparam logic [2:0]  PRIO_BITS_M1   = 3'h4;
  localparam logic [2:0]  PREEMPT_BITS_M1 = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_EOI_MODE = 9;
  localparam int LR_ID_LSB    = 0;
  localparam int LR_PRIO_LSB  = 23;
  localparam int LR_PEND_BIT  = 28;
  localparam int LR_ACT_BIT   = 29;
  localparam logic [31:0] LR_WMASK = 32'h3F8003FF;
  localparam int EVT_ACK      = 0;
  localparam int EVT_EOI_MISS = 1;
  localparam int EVT_DIR_MISS = 2;
  localparam int EVT_COUNT    = 3;

endpackage

// ---- hdl/vcii_core.sv ----
//
// Function
// - Type register bits 31..29 read priority bit count minus one, value 4.
// - Type register bits 28..26 read preemption bit count minus one, value 4.
// - Type register low six bits read list register count minus one, 3.
// - Registers are reached only as whole aligned 32-bit words.
// - Unlisted offsets read zero and ignore writes.
// - Virtual interrupts obey priority mask, preemption and priority ordering.
// - Signalling to the core is decided from current list register contents.
// - Acknowledge, deactivate and, with control EOI mode bit 9 clear, end accesses update list register entries.
// - Virtual active priority aliases the hypervisor active priorities storage.
// - Writing back the value read from active priority changes nothing.
// - Identification register uses the physical interface layout and values.
// - Control, priority mask and active priority reset to zero.
// - Binary point resets to two, aliased binary point to three.
// - Running priority resets to all ones in its low byte.
// - Acknowledge and highest pending registers reset to spurious id 1023.
// - End, aliased end and deactivate are write-only; deactivate at 0x1000.
// - Identification holds implementer, revision, architecture and product fields.
//
// The strobed register port was decided locally.
module vcii_core #(
  parameter int          LR_COUNT     = 4,
  parameter logic [11:0] IMPLEMENTER  = 12'h5A5,  // Arbitrary value
  parameter logic [3:0]  REVISION     = 4'h0,
  parameter logic [3:0]  ARCH_VERSION = 4'h2,
  parameter logic [11:0] PRODUCT_ID   = 12'h000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [13:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  // Interrupt outputs
  output logic             virq_o,
  output logic             irq_o
);

  localparam int EVT_COUNT  = vcii_pkg::EVT_COUNT;
  localparam int LR_ACT_BIT = vcii_pkg::LR_ACT_BIT;
  localparam int LR_ID_LSB  = vcii_pkg::LR_ID_LSB;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Group priority of a 5-bit priority under a binary point
  function automatic logic [7:0] group_prio(input logic [4:0] p, input logic [2:0] b);
    logic [7:0] m;
    m = 8'hFF << (4'(b) + 4'h1);
    return {p, 3'h0} & m;
  endfunction

  // Bit set of active entries carrying the given id, one bit per list entry
  function automatic logic [LR_COUNT-1:0] find_active(
    input logic [LR_COUNT-1:0][31:0] lrs, input logic [9:0] id);
    logic [LR_COUNT-1:0] hit;
    hit = '0;
    for (int i = 0; i < LR_COUNT; i++) begin
      hit[i] = lrs[i][LR_ACT_BIT] && (lrs[i][LR_ID_LSB +: 10] == id);
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [9:0]                ctl_q;
  logic [7:0]                pmr_q;
  logic [2:0]                bpr_q;
  logic [2:0]                abpr_q;
  logic [31:0]               apr_q;
  logic [LR_COUNT-1:0][31:0] lr_q;
  logic [EVT_COUNT-1:0]      status_q;
  logic [EVT_COUNT-1:0]      mask_q;
  logic [31:0]               rdata_q;
  logic                      virq_q;
  logic                      irq_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic        aligned;
  logic        wr_ack_ro;
  logic        rd_ack;
  logic        wr_eoi;
  logic        wr_dir;
  logic        wr_apr;
  logic [3:0]  lr_sel;
  logic        lr_hit;

  assign aligned   = (addr_i[1:0] == 2'h0);
  assign rd_ack    = re_i && ((addr_i == vcii_pkg::OFS_ACK) || (addr_i == vcii_pkg::OFS_AACK));
  assign wr_eoi    = we_i && ((addr_i == vcii_pkg::OFS_EOI) || (addr_i == vcii_pkg::OFS_AEOI));
  assign wr_dir    = we_i && (addr_i == vcii_pkg::OFS_DEACTIVATE);
  assign wr_apr    = we_i && ((addr_i == vcii_pkg::OFS_ACT_PRIO) ||
                              (addr_i == vcii_pkg::OFS_HYP_APR));
  assign wr_ack_ro = we_i && ((addr_i == vcii_pkg::OFS_ACK) || (addr_i == vcii_pkg::OFS_AACK));
  assign lr_sel    = addr_i[5:2];
  assign lr_hit    = aligned && (addr_i[13:6] == vcii_pkg::OFS_LIST_BASE[13:6]) &&
                     (32'(lr_sel) < LR_COUNT);

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  logic                best_valid;
  logic [1:0]          best_idx;
  logic [4:0]          best_prio;
  logic [9:0]          best_id;
  logic [7:0]          run_prio;
  logic [7:0]          best_group;
  logic                hp_valid;
  logic                sig_cond;

  // Lowest priority value among pending entries, lowest index on a tie
  always_comb begin
    best_valid = 1'b0;
    best_idx   = 2'h0;
    best_prio  = 5'h1F;
    for (int i = 0; i < LR_COUNT; i++) begin
      if (lr_q[i][vcii_pkg::LR_PEND_BIT] && !lr_q[i][LR_ACT_BIT] &&
          (!best_valid || (lr_q[i][vcii_pkg::LR_PRIO_LSB +: 5] < best_prio))) begin
        best_valid = 1'b1;
        best_idx   = 2'(i);
        best_prio  = lr_q[i][vcii_pkg::LR_PRIO_LSB +: 5];
      end
    end
  end

  assign best_id = lr_q[best_idx][LR_ID_LSB +: 10];

  // Running priority is the lowest active priority level
  always_comb begin
    run_prio = vcii_pkg::IDLE_PRIORITY;
    for (int i = 31; i >= 0; i--) begin
      if (apr_q[i]) begin
        run_prio = {5'(i), 3'h0};
      end
    end
  end

  assign best_group = group_prio(best_prio, bpr_q);
  assign hp_valid   = best_valid && ({best_prio, 3'h0} < {pmr_q[7:3], 3'h0}) &&
                      (best_group < run_prio);
  assign sig_cond   = ctl_q[vcii_pkg::CTL_ENABLE] && hp_valid;

  // ----------------------------------------------------------------
  // Completion events
  // ----------------------------------------------------------------
  logic                ack;
  logic [LR_COUNT-1:0] end_hit;
  logic [31:0]         apr_low;

  assign ack     = rd_ack && sig_cond;
  assign end_hit = find_active(lr_q, wdata_i[9:0]);
  assign apr_low = apr_q & (~apr_q + 32'h1);

  // ----------------------------------------------------------------
  // Virtual control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q  <= vcii_pkg::RST_CONTROL;
      pmr_q  <= vcii_pkg::RST_PRIO_MASK;
      bpr_q  <= vcii_pkg::RST_BIN_POINT;
      abpr_q <= vcii_pkg::RST_ABIN_POINT;
    end else if (we_i) begin
      unique case (addr_i)
        vcii_pkg::OFS_CONTROL:    ctl_q  <= wdata_i[9:0];
        vcii_pkg::OFS_PRIO_MASK:  pmr_q  <= {wdata_i[7:3], 3'h0};
        vcii_pkg::OFS_BIN_POINT:  bpr_q  <= wdata_i[2:0];
        vcii_pkg::OFS_ABIN_POINT: abpr_q <= wdata_i[2:0];
        default: begin
        end
      endcase
    end
  end

  // Shared active priority storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      apr_q <= vcii_pkg::RST_ACT_PRIO;
    end else if (wr_apr) begin
      apr_q <= wdata_i;
    end else if (ack) begin
      apr_q[best_group[7:3]] <= 1'b1;
    end else if (wr_eoi) begin
      apr_q <= apr_q & ~apr_low;
    end
  end

  // List registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lr_q <= '0;
    end else if (we_i && lr_hit) begin
      lr_q[lr_sel[1:0]] <= wdata_i & vcii_pkg::LR_WMASK;
    end else if (ack) begin
      lr_q[best_idx][vcii_pkg::LR_PEND_BIT] <= 1'b0;
      lr_q[best_idx][LR_ACT_BIT]            <= 1'b1;
    end else if ((wr_eoi && !ctl_q[vcii_pkg::CTL_EOI_MODE]) || wr_dir) begin
      for (int i = 0; i < LR_COUNT; i++) begin
        if (end_hit[i]) begin
          lr_q[i][LR_ACT_BIT] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupts
  // ----------------------------------------------------------------
  logic [EVT_COUNT-1:0] evt_set;
  logic [EVT_COUNT-1:0] evt_clr;

  assign evt_set = {wr_dir && (end_hit == '0), wr_eoi && (end_hit == '0), ack};
  assign evt_clr = (we_i && (addr_i == vcii_pkg::OFS_EVT_STATUS)) ?
                   wdata_i[EVT_COUNT-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (we_i && (addr_i == vcii_pkg::OFS_EVT_MASK)) begin
      mask_q <= wdata_i[EVT_COUNT-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      virq_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      virq_q <= sig_cond;
      irq_q  <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [9:0]  pend_id;

  assign pend_id = sig_cond ? best_id : vcii_pkg::SPURIOUS_ID;

  always_comb begin
    rd_mux = 32'h0;
    if (lr_hit) begin
      rd_mux = lr_q[lr_sel[1:0]];
    end else begin
      unique case (addr_i)
        vcii_pkg::OFS_CONTROL:    rd_mux = {22'h0, ctl_q};
        vcii_pkg::OFS_PRIO_MASK:  rd_mux = {24'h0, pmr_q};
        vcii_pkg::OFS_BIN_POINT:  rd_mux = {29'h0, bpr_q};
        vcii_pkg::OFS_ABIN_POINT: rd_mux = {29'h0, abpr_q};
        vcii_pkg::OFS_ACK,
        vcii_pkg::OFS_AACK,
        vcii_pkg::OFS_HIGH_PEND,
        vcii_pkg::OFS_AHIGH_PEND: rd_mux = {22'h0, pend_id};
        vcii_pkg::OFS_RUN_PRIO:   rd_mux = {24'h0, run_prio};
        vcii_pkg::OFS_ACT_PRIO,
        vcii_pkg::OFS_HYP_APR:    rd_mux = apr_q;
        vcii_pkg::OFS_IDENT:      rd_mux = {PRODUCT_ID, ARCH_VERSION, REVISION,
                                            IMPLEMENTER};
        vcii_pkg::OFS_TYPE:       rd_mux = {vcii_pkg::PRIO_BITS_M1,
                                            vcii_pkg::PREEMPT_BITS_M1, 20'h0,
                                            6'(LR_COUNT - 1)};
        vcii_pkg::OFS_EVT_STATUS: rd_mux = {29'h0, status_q};
        vcii_pkg::OFS_EVT_MASK:   rd_mux = {29'h0, mask_q};
        default:                  rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= re_i ? rd_mux : 32'h0;
    end
  end

  assign rdata_o = rdata_q;
  assign virq_o  = virq_q;
  assign irq_o   = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hyp_apr_write;
    we_i && (addr_i == vcii_pkg::OFS_HYP_APR);
  endsequence
  sequence s_vm_apr_read;
    re_i && (addr_i == vcii_pkg::OFS_ACT_PRIO);
  endsequence

  a_type_prio_bits: assert property (
    (re_i && addr_i == vcii_pkg::OFS_TYPE) |=> rdata_o[31:29] == 3'h4)
    else $error("type priority bits wrong");
  a_type_preempt_bits: assert property (
    (re_i && addr_i == vcii_pkg::OFS_TYPE) |=> rdata_o[28:26] == 3'h4)
    else $error("type preemption bits wrong");
  a_type_list_count: assert property (
    (re_i && addr_i == vcii_pkg::OFS_TYPE) |=> rdata_o[25:0] == 26'h3)
    else $error("type list count wrong");
  a_unmapped_zero: assert property (
    (re_i && !aligned) |=> rdata_o == 32'h0)
    else $error("unaligned read not zero");
  a_mask_blocks: assert property (
    (best_valid && ({best_prio, 3'h0} >= pmr_q)) |=> !virq_o)
    else $error("masked interrupt signalled");
  a_signal_follows: assert property (
    sig_cond |=> virq_o ##0 $past(best_valid))
    else $error("virtual interrupt not signalled");
  a_ack_updates: assert property (
    ack |=> (rdata_o[9:0] == $past(best_id)) && (apr_q != 32'h0) &&
            lr_q[$past(best_idx)][LR_ACT_BIT] [*1])
    else $error("acknowledge did not update state");
  a_apr_alias: assert property (
    s_hyp_apr_write ##1 (!we_i && !re_i) ##1 s_vm_apr_read |=>
      rdata_o == $past(wdata_i, 3))
    else $error("active priority alias broken");
  a_apr_writeback: assert property (
    (wr_apr && wdata_i == apr_q) |=> $stable(apr_q) && $stable(lr_q))
    else $error("write back changed state");
  a_ident_layout: assert property (
    (re_i && addr_i == vcii_pkg::OFS_IDENT) |=>
      rdata_o == {PRODUCT_ID, ARCH_VERSION, REVISION, IMPLEMENTER})
    else $error("identification value wrong");
  a_reset_values: assert property (disable iff (1'b0)
    rst_i |=> ctl_q == 10'h0 && pmr_q == 8'h0 && apr_q == 32'h0 &&
              bpr_q == 3'h2 && abpr_q == 3'h3)
    else $error("reset values wrong");
  a_idle_running: assert property (
    (re_i && addr_i == vcii_pkg::OFS_RUN_PRIO && apr_q == 32'h0) |=> rdata_o == 32'hFF)
    else $error("idle running priority wrong");
  a_spurious_ack: assert property (
    (rd_ack && !sig_cond) |=> rdata_o == 32'h3FF)
    else $error("spurious id not returned");
  a_write_only: assert property (
    (re_i && (addr_i == vcii_pkg::OFS_EOI || addr_i == vcii_pkg::OFS_DEACTIVATE))
      |=> rdata_o == 32'h0)
    else $error("write-only register read nonzero");
  a_ro_write_ignored: assert property (
    wr_ack_ro |=> $stable(lr_q) && $stable(apr_q) && $stable(status_q))
    else $error("read-only write changed state");
  a_spurious_no_change: assert property (
    (rd_ack && !sig_cond) |=> $stable(lr_q) && $stable(apr_q))
    else $error("spurious acknowledge changed state");
  a_eoi_drops_prio: assert property (
    (wr_eoi && apr_q != 32'h0) |=> apr_q == ($past(apr_q) & ($past(apr_q) - 32'h1)))
    else $error("end did not drop highest active priority");
  a_pending_read_pure: assert property (
    (re_i && (addr_i == vcii_pkg::OFS_HIGH_PEND || addr_i == vcii_pkg::OFS_AHIGH_PEND))
      |=> $stable(lr_q) && $stable(apr_q))
    else $error("highest pending read changed state");

endmodule

// ---- test/vcii_cpu_model.sv ----
module vcii_cpu_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Interrupt line from the interface
  input  wire logic       virq_i,
  // Observation
  output logic      [7:0] virq_edges_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Core side: counts each new virtual interrupt it is offered
  // ----------------------------------------------------------------
  logic virq_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      virq_q       <= 1'b0;
      virq_edges_o <= 8'h00;
    end else begin
      virq_q <= virq_i;
      if (virq_i && !virq_q) begin
        virq_edges_o <= virq_edges_o + 8'h01;
      end
    end
  end
endmodule

// ---- test/vcii_core_tb.sv ----
module vcii_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] IMPL  = 12'h5A5;  // Arbitrary value
  localparam logic [31:0] IDENT = {12'h000, 4'h2, 4'h0, IMPL};
  localparam logic [13:0] LR0   = vcii_pkg::OFS_LIST_BASE;
  localparam logic [13:0] LR1   = vcii_pkg::OFS_LIST_BASE + 14'h0004;

  logic        clk;
  logic        rst;
  logic        we;
  logic        re;
  logic        virq;
  logic        irq;
  logic [13:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [7:0]  virq_edges;
  int          num_errors;
  int          checked;
  logic [13:0] ra [17];
  logic [31:0] rv [17];

  vcii_core #(
    .LR_COUNT     (4),
    .IMPLEMENTER  (IMPL),
    .REVISION     (4'h0),
    .ARCH_VERSION (4'h2),
    .PRODUCT_ID   (12'h000)
  ) i_vcii_core (
    .clk_i   (clk),
    .rst_i   (rst),
    .addr_i  (addr),
    .wdata_i (wdata),
    .we_i    (we),
    .re_i    (re),
    .rdata_o (rdata),
    .virq_o  (virq),
    .irq_o   (irq)
  );

  vcii_cpu_model i_vcii_cpu_model (
    .clk_i        (clk),
    .rst_i        (rst),
    .virq_i       (virq),
    .virq_edges_o (virq_edges)
  );

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    we    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp, input string msg);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re   <= 1'b0;
    #1;
    chk(rdata, exp, msg);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_table();
    for (int i = 0; i < 17; i++) begin
      rd_chk(ra[i], rv[i], "table");
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    $display("MISMATCH at %0t: run did not finish", $time);
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 14'h0000;
    wdata = 32'h00000000;
    num_errors = 0;
    checked = 0;
    ra = '{14'h0000, 14'h0004, 14'h0008, 14'h000C, 14'h0010, 14'h0014, 14'h0018, 14'h001C,
           14'h0020, 14'h0024, 14'h0028, 14'h00D0, 14'h00FC, 14'h1000, vcii_pkg::OFS_TYPE,
           14'h0030, 14'h0006};
    rv = '{32'h0, 32'h0, 32'h2, 32'h3FF, 32'h0, 32'hFF, 32'h3FF, 32'h3, 32'h3FF, 32'h0,
           32'h3FF, 32'h0, IDENT, 32'h0, 32'h90000003, 32'h0, 32'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    check_table();
    $display("test reset values done");

    // Read-only, unmapped and misaligned writes leave everything alone
    for (int i = 0; i < 17; i++) begin
      if ((rv[i] != 32'h0 && ra[i] != 14'h0008 && ra[i] != 14'h001C) || ra[i] == 14'h0030) begin
        wr(ra[i], 32'hFFFFFFFF);
      end
    end
    wr(14'h0002, 32'h00000001);
    check_table();
    $display("test ignored writes done");

    // Active priority alias and write-back of a read value
    wr(vcii_pkg::OFS_ACT_PRIO, 32'h00000005);
    rd_chk(vcii_pkg::OFS_HYP_APR, 32'h00000005, "alias view");
    wr(vcii_pkg::OFS_HYP_APR, 32'h00000009);
    rd_chk(vcii_pkg::OFS_ACT_PRIO, 32'h00000009, "alias back");
    wr(vcii_pkg::OFS_ACT_PRIO, 32'h00000009);
    rd_chk(vcii_pkg::OFS_ACT_PRIO, 32'h00000009, "write back");
    rd_chk(vcii_pkg::OFS_RUN_PRIO, 32'h00000000, "running from alias");
    wr(vcii_pkg::OFS_ACT_PRIO, 32'h00000000);
    rd_chk(vcii_pkg::OFS_RUN_PRIO, 32'h000000FF, "running idle");
    $display("test active priority done");

    // Delivery, acknowledge and end of two list entries
    wr(vcii_pkg::OFS_EVT_MASK, 32'h00000007);
    wr(LR0, 32'h11000021);
    wr(LR1, 32'h10800022);
    wr(vcii_pkg::OFS_CONTROL, 32'h00000001);
    idle(3);
    chk(virq, 1'b0, "mask zero blocks");
    wr(vcii_pkg::OFS_PRIO_MASK, 32'h000000F8);
    idle(3);
    chk(virq, 1'b1, "signal raised");
    rd_chk(vcii_pkg::OFS_HIGH_PEND, 32'h00000022, "highest pending");
    rd_chk(vcii_pkg::OFS_ACK, 32'h00000022, "acknowledge");
    rd_chk(LR1, 32'h20800022, "entry active");
    rd_chk(vcii_pkg::OFS_RUN_PRIO, 32'h00000008, "running prio");
    rd_chk(vcii_pkg::OFS_ACT_PRIO, 32'h00000002, "active prio bit");
    idle(2);
    chk(virq, 1'b0, "lower priority waits");
    chk(irq, 1'b1, "ack event");
    wr(vcii_pkg::OFS_EOI, 32'h00000022);
    rd_chk(LR1, 32'h00800022, "entry ended");
    rd_chk(vcii_pkg::OFS_RUN_PRIO, 32'h000000FF, "running idle again");
    idle(2);
    chk(virq, 1'b1, "second signal");
    rd_chk(vcii_pkg::OFS_AACK, 32'h00000021, "aliased acknowledge");
    rd_chk(LR0, 32'h21000021, "entry0 active");
    wr(vcii_pkg::OFS_AEOI, 32'h00000021);
    rd_chk(LR0, 32'h01000021, "entry0 ended");
    idle(2);
    chk(virq, 1'b0, "nothing pending");
    rd_chk(vcii_pkg::OFS_ACK, 32'h000003FF, "spurious");
    chk(virq_edges, 8'h02, "deliveries seen");
    $display("test delivery done");

    // Event status, mask and clear
    wr(vcii_pkg::OFS_EOI, 32'h00000003);
    wr(vcii_pkg::OFS_DEACTIVATE, 32'h00000005);
    rd_chk(vcii_pkg::OFS_EVT_STATUS, 32'h00000007, "event status");
    wr(vcii_pkg::OFS_EVT_MASK, 32'h00000000);
    idle(2);
    chk(irq, 1'b0, "masked");
    wr(vcii_pkg::OFS_EVT_MASK, 32'h00000007);
    idle(2);
    chk(irq, 1'b1, "unmasked");
    wr(vcii_pkg::OFS_EVT_STATUS, 32'h00000007);
    idle(2);
    chk(irq, 1'b0, "cleared");
    rd_chk(vcii_pkg::OFS_EVT_STATUS, 32'h00000000, "status empty");
    $display("test events done");
    close_out();
  end
endmodule
